// *** src/io_port_channel.sv ***
// One port's channel logic: inputs, outputs, overload, failsafe, swapping, alarms
`default_nettype none
`include "io_port_regs.svh"
module io_port_channel import io_port_pkg::*; #(
    parameter int MS_CYC = `T_MS_NS / `CLK_PERIOD_NS,
    parameter int RESTART_MS = `T_RESTART_MS,
    parameter int FILTER_MS = `T_FILTER_MS
) (
    input wire logic CLK_SYS, // System clock, 200 MHz
    input wire logic RSTN, // Asynchronous reset, active low
    input wire logic HSEL, // Slave select
    input wire logic [31:0] HADDR, // Byte address
    input wire logic [1:0] HTRANS, // Transfer type
    input wire logic HWRITE, // Write when high
    input wire logic [2:0] HSIZE, // Writes take effect for word transfers only; reads ignore the size
    input wire logic [31:0] HWDATA, // Write data
    input wire logic HREADY, // Bus ready
    output logic HREADYOUT, // Slave ready
    output logic HRESP, // Always OKAY
    output logic [31:0] HRDATA, // Read data
    input wire logic NET_LOST, // Network communication lost, same clock
    input wire logic SENSE_A, // Channel A sensed_line pin
    input wire logic SENSE_B, // Channel B sensed_line pin
    input wire logic OVL_A, // Channel A overload from driver pin
    output logic DO_A_O, // Channel A output level
    output logic DO_A_OE, // Channel A output enable
    output logic [2:0] CLIMIT_A, // Current limit code to driver
    output logic DO_B_O, // Channel B output level
    output logic DO_B_OE, // Channel B output enable
    output logic PWR_B, // Channel B switched power on
    output logic LED_A, // Channel A indicator
    output logic LED_PORT, // Port power indicator
    output logic DIAG_A, // Channel A diagnostic
    input wire logic DEV_ERR, // Device error alarm pulse
    input wire logic DEV_WARN, // Device warning alarm pulse
    input wire logic DEV_NOTIF, // Device notification pulse
    output logic ALM_ERR, // Forwarded error alarm
    output logic ALM_WARN, // Forwarded warning alarm
    output logic ALM_NOTIF, // Forwarded notification
    input wire logic [31:0] SD_PDIN, // Serial-device input data
    output logic [31:0] SD_PDOUT, // Serial-device output data
    output logic SD_PDOUT_VALID // Serial-device output data valid
);
    localparam int MSW = $clog2(MS_CYC + 1);
    localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYC - 1);
    localparam logic [7:0] RESTART_N = 8'(RESTART_MS);
    localparam logic [7:0] FILTER_N = 8'(FILTER_MS);

    function automatic logic fs_level(input fs_do_t m, input logic held);
        case (m)
            FS_HIGH: fs_level = 1'b1;
            FS_HOLD: fs_level = held;
            default: fs_level = 1'b0;
        endcase
    endfunction

    // Register file
    cfg_t cfg;
    logic [7:0] mon_ms;
    logic [1:0] ctrl;
    swap_cfg_t swap_in;
    swap_cfg_t swap_out;
    logic [3:0] sdfs;
    logic [31:0] subst;
    logic [31:0] pdout;

    // Bus address phase capture
    logic wr_pend;
    logic [7:0] wr_addr;
    wire logic addr_ok = HSEL && HREADY && HTRANS[1];
    wire logic rd_req = addr_ok && !HWRITE;
    wire logic wr_req = addr_ok && HWRITE && HSIZE == 3'h2;
    wire logic upper_zero = HADDR[31:8] == 24'h0;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= wr_req && upper_zero;
            wr_addr <= HADDR[7:0];
        end
    end

    wire logic wr_cfg = wr_pend && wr_addr == `OFS_CFG;
    wire logic wr_mon = wr_pend && wr_addr == `OFS_MON;
    wire logic wr_ctrl = wr_pend && wr_addr == `OFS_CTRL;
    wire logic wr_swap = wr_pend && wr_addr == `OFS_SWAP;
    wire logic wr_sdfs = wr_pend && wr_addr == `OFS_SDFS;
    wire logic wr_subst = wr_pend && wr_addr == `OFS_SUBST;
    wire logic wr_pdout = wr_pend && wr_addr == `OFS_PDOUT;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cfg <= `CFG_RST;
            mon_ms <= `MON_RST;
            ctrl <= `CTRL_RST;
            {swap_out, swap_in} <= `SWAP_RST;
            sdfs <= `SDFS_RST;
            subst <= `SUBST_RST;
            pdout <= `PDOUT_RST;
        end else begin
            if (wr_cfg) cfg <= HWDATA;
            if (wr_mon) mon_ms <= HWDATA[7:0];
            if (wr_ctrl) ctrl <= HWDATA[1:0];
            if (wr_swap) {swap_out, swap_in} <= HWDATA;
            if (wr_sdfs) sdfs <= HWDATA[3:0];
            if (wr_subst) subst <= HWDATA;
            if (wr_pdout) pdout <= HWDATA;
        end
    end

    // Pin synchronisers; a level counts once the second and third stages agree
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] pins;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            pins <= 3'h0;
        end else begin
            sync1 <= {OVL_A, SENSE_B, SENSE_A};
            sync2 <= sync1;
            sync3 <= sync2;
            pins <= (sync2 & sync3) | (pins & (sync2 | sync3));
        end
    end
    wire logic sense_a = pins[0];
    wire logic sense_b = pins[1];
    wire logic ovl_a = pins[2];

    // Millisecond tick shared by all timers
    logic [MSW-1:0] ms_div;
    wire logic ms_tick = ms_div == MS_LAST;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) ms_div <= '0;
        else ms_div <= ms_tick ? '0 : ms_div + MSW'(1);
    end

    // Failsafe levels; hold captures the last state while the network is up
    logic held_a;
    logic held_b;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            held_a <= 1'b0;
            held_b <= 1'b0;
        end else if (!NET_LOST) begin
            held_a <= ctrl[`CTRL_A_BIT];
            held_b <= ctrl[`CTRL_B_BIT];
        end
    end
    wire logic cmd_a = NET_LOST ? fs_level(cfg.fs_do, held_a) : ctrl[`CTRL_A_BIT];
    wire logic cmd_b = NET_LOST ? fs_level(cfg.fs_do, held_b) : ctrl[`CTRL_B_BIT];

    // Output A overload supervision
    out_state_t state;
    out_state_t next_state;
    logic [7:0] surv;
    logic [7:0] flt;
    logic [7:0] rst_cnt;
    wire logic monitored = surv == 8'h00;
    wire logic fault_hit = flt == FILTER_N;
    wire logic retry_due = rst_cnt == RESTART_N;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: if (cmd_a) next_state = ST_ON;
            ST_ON: begin
                if (!cmd_a) next_state = ST_IDLE;
                else if (fault_hit && cfg.restart_manual) next_state = ST_TRIP_HOLD;
                else if (fault_hit) next_state = ST_TRIP_AUTO;
            end
            ST_TRIP_AUTO: begin
                if (!cmd_a) next_state = ST_IDLE;
                else if (retry_due) next_state = ST_ON;
            end
            ST_TRIP_HOLD: if (!cmd_a) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // A retry counts as a fresh switch-on, so the inrush is masked again
    wire logic switch_on = next_state == ST_ON && state != ST_ON;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state <= ST_IDLE;
            surv <= 8'h00;
            flt <= 8'h00;
            rst_cnt <= 8'h00;
        end else begin
            state <= next_state;
            if (switch_on) surv <= mon_ms;
            else if (ms_tick && !monitored) surv <= surv - 8'h01;
            if (state != ST_ON || !ovl_a || !monitored) flt <= 8'h00;
            else if (ms_tick && !fault_hit) flt <= flt + 8'h01;
            if (state != ST_TRIP_AUTO) rst_cnt <= 8'h00;
            else if (ms_tick && !retry_due) rst_cnt <= rst_cnt + 8'h01;
        end
    end

    wire logic on_a = state == ST_ON;
    wire logic tripped = state == ST_TRIP_AUTO || state == ST_TRIP_HOLD;
    wire logic rep_a = sense_a ^ cfg.polarity_nc;
    wire logic rep_b = cfg.chb_mode == CHB_DIN && (sense_b ^ cfg.polarity_nc);
    // Push-pull runs at a fixed limit; the driver's overload flag follows this code
    wire logic [2:0] climit = cfg.push_pull ? 3'(CL_0A5) : 3'(cfg.climit);

    // Serial-device data paths
    logic [31:0] pdin_sw;
    logic [31:0] pdout_sw;
    byte_swap #(.NB(`PD_BYTES)) u_swap_in (
        .din(SD_PDIN),
        .cfg(swap_in),
        .dout(pdin_sw)
    );
    byte_swap #(.NB(`PD_BYTES)) u_swap_out (
        .din(pdout),
        .cfg(swap_out),
        .dout(pdout_sw)
    );

    logic [31:0] last_valid;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) last_valid <= 32'h0000_0000;
        else if (!NET_LOST) last_valid <= pdout_sw;
    end

    sd_out_t next_sd;
    always_comb begin
        next_sd = '{valid: 1'b1, data: pdout_sw};
        if (NET_LOST) begin
            case (sdfs_t'(sdfs[2:0]))
                SFS_LOW: next_sd.data = 32'h0000_0000;
                SFS_HIGH: next_sd.data = 32'hffff_ffff;
                SFS_HOLD: next_sd.data = last_valid;
                // Byte 1 or word 1 sits in the top lane, so it leaves first
                SFS_SUBST: next_sd.data = subst;
                SFS_MCMD: next_sd = '{valid: 1'b0, data: last_valid};
                default: next_sd.data = 32'h0000_0000;
            endcase
        end
    end

    logic [31:0] pdin;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            pdin <= 32'h0000_0000;
            {SD_PDOUT_VALID, SD_PDOUT} <= '0;
        end else begin
            pdin <= pdin_sw;
            {SD_PDOUT_VALID, SD_PDOUT} <= next_sd;
        end
    end

    // Pin and alarm outputs, all registered
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            DO_A_O <= 1'b0;
            DO_A_OE <= 1'b0;
            CLIMIT_A <= 3'h0;
            DO_B_O <= 1'b0;
            DO_B_OE <= 1'b0;
            PWR_B <= 1'b0;
            LED_A <= 1'b0;
            LED_PORT <= 1'b0;
            DIAG_A <= 1'b0;
            ALM_ERR <= 1'b0;
            ALM_WARN <= 1'b0;
            ALM_NOTIF <= 1'b0;
        end else begin
            DO_A_O <= on_a;
            DO_A_OE <= cfg.push_pull || on_a;
            CLIMIT_A <= climit;
            DO_B_O <= cfg.chb_mode == CHB_DOUT && cmd_b;
            DO_B_OE <= cfg.chb_mode == CHB_DOUT && cmd_b;
            PWR_B <= cfg.chb_mode == CHB_PWR;
            LED_A <= sense_a;
            LED_PORT <= cfg.chb_mode == CHB_PWR;
            DIAG_A <= tripped && cfg.diag_en;
            ALM_ERR <= DEV_ERR && cfg.diag_en;
            ALM_WARN <= DEV_WARN && cfg.diag_en;
            ALM_NOTIF <= DEV_NOTIF && cfg.notif_en;
        end
    end

    // Read path: status shows the block's own state
    wire logic [31:0] stat = {24'h0, NET_LOST, DIAG_A, tripped, on_a,
                              sense_b, sense_a, rep_b, rep_a};
    wire logic [7:0] ra = HADDR[7:0];
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (!upper_zero) rd_mux = 32'h0000_0000;
        else if (ra == `OFS_CFG) rd_mux = cfg;
        else if (ra == `OFS_MON) rd_mux = {24'h0, mon_ms};
        else if (ra == `OFS_CTRL) rd_mux = {30'h0, ctrl};
        else if (ra == `OFS_SWAP) rd_mux = {swap_out, swap_in};
        else if (ra == `OFS_SDFS) rd_mux = {28'h0, sdfs};
        else if (ra == `OFS_SUBST) rd_mux = subst;
        else if (ra == `OFS_PDOUT) rd_mux = pdout;
        else if (ra == `OFS_PDIN) rd_mux = pdin;
        else if (ra == `OFS_STAT) rd_mux = stat;
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HRDATA <= rd_req ? rd_mux : 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** src/io_port_regs.svh ***
// Register offsets, reset values and timing constants of the port channel block
`ifndef IO_PORT_REGS_SVH
`define IO_PORT_REGS_SVH

`define OFS_CFG 8'h00
`define OFS_MON 8'h04
`define OFS_CTRL 8'h08
`define OFS_SWAP 8'h0c
`define OFS_SDFS 8'h10
`define OFS_SUBST 8'h14
`define OFS_PDOUT 8'h18
`define OFS_PDIN 8'h1c
`define OFS_STAT 8'h20

`define CFG_RST 32'h0000_0d20
`define MON_RST 8'h50
`define CTRL_RST 2'h0
`define SWAP_RST 32'h0000_0000
`define SDFS_RST 4'h0
`define SUBST_RST 32'h0000_0000
`define PDOUT_RST 32'h0000_0000

`define CTRL_A_BIT 0
`define CTRL_B_BIT 1
`define SDFS_WORD_BIT 3

`define CLK_PERIOD_NS 5
`define T_MS_NS 1000000
`define T_FILTER_MS 5
`define T_RESTART_MS 100
`define PD_BYTES 4

`endif

// *** src/io_port_pkg.sv ***
// Types shared by the port channel block
`default_nettype none
package io_port_pkg;
    typedef enum logic [2:0] {CL_0A5, CL_1A0, CL_1A5, CL_2A0, CL_MAX} climit_t;
    typedef enum logic [1:0] {FS_LOW, FS_HIGH, FS_HOLD, FS_RSV} fs_do_t;
    typedef enum logic [1:0] {CHB_OFF, CHB_DIN, CHB_DOUT, CHB_PWR} chb_t;
    typedef enum logic [2:0] {
        SFS_LOW, SFS_HIGH, SFS_HOLD, SFS_SUBST, SFS_MCMD
    } sdfs_t;
    typedef enum logic [1:0] {SW_OFF, SW_COUNT, SW_ALL, SW_RSV} swap_mode_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ON = 4'b0010,
        ST_TRIP_AUTO = 4'b0100,
        ST_TRIP_HOLD = 4'b1000
    } out_state_t;
    typedef struct packed {
        logic [19:0] rsv;
        logic notif_en;
        logic diag_en;
        chb_t chb_mode;
        fs_do_t fs_do;
        climit_t climit;
        logic push_pull;
        logic restart_manual;
        logic polarity_nc;
    } cfg_t;
    typedef struct packed {
        logic [3:0] offset;
        logic [3:0] count;
        logic [4:0] rsv;
        logic dword;
        swap_mode_t mode;
    } swap_cfg_t;
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } sd_out_t;
endpackage
`default_nettype wire

// *** src/byte_swap.sv ***
// Byte order swapping of serial-device process data, first byte in the top lane
`default_nettype none
module byte_swap import io_port_pkg::*; #(
    parameter int NB = 4
) (
    input wire logic [8*NB-1:0] din, // Data in transmission order
    input wire swap_cfg_t cfg, // Swap setup for this direction
    output logic [8*NB-1:0] dout // Swapped data
);
    function automatic int src_idx(input int i, input swap_cfg_t c);
        int u;
        int rel;
        int grp;
        u = c.dword ? 4 : 2;
        if (c.mode == SW_OFF || i < int'(c.offset)) begin
            return i;
        end
        rel = i - int'(c.offset);
        grp = rel / u;
        // A partial unit at the tail is left alone rather than half swapped
        if ((grp + 1) * u > NB - int'(c.offset)) begin
            return i;
        end
        if (c.mode == SW_COUNT && grp >= int'(c.count)) begin
            return i;
        end
        return int'(c.offset) + grp * u + u - 1 - (rel % u);
    endfunction

    always_comb begin
        dout = '0;
        for (int i = 0; i < NB; i++) begin
            dout[8*(NB-1-i) +: 8] = din[8*(NB-1-src_idx(i, cfg)) +: 8];
        end
    end
endmodule
`default_nettype wire

// *** tb/io_port_chk.sv ***
// Concurrent assertions on the ports of the port channel block
`default_nettype none
module io_port_chk #(
    parameter int MS_CYC = 10,
    parameter int FILTER_MS = 5
) (
    input wire logic CLK_SYS, // Clock
    input wire logic RSTN, // Reset, active low
    input wire logic HREADYOUT, // Ready out
    input wire logic HRESP, // Response
    input wire logic NET_LOST, // Network lost
    input wire logic SENSE_A, // Input pin A
    input wire logic OVL_A, // Overload pin A
    input wire logic DO_A_O, // Output A level
    input wire logic DO_A_OE, // Output A enable
    input wire logic [2:0] CLIMIT_A, // Limit code
    input wire logic DO_B_OE, // Output B enable
    input wire logic PWR_B, // Power output
    input wire logic LED_A, // Channel indicator
    input wire logic LED_PORT, // Port indicator
    input wire logic DIAG_A, // Diagnostic A
    input wire logic DEV_ERR, // Device error in
    input wire logic DEV_NOTIF, // Device notification in
    input wire logic ALM_ERR, // Error out
    input wire logic ALM_NOTIF, // Notification out
    input wire logic SD_PDOUT_VALID // Serial data valid
);
    timeunit 1ns / 1ps;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    int ovl_run;
    // Length of the present overload, to bound how early a diagnostic may rise
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ovl_run <= 0;
        end else begin
            ovl_run <= OVL_A ? ovl_run + 1 : 0;
        end
    end
    ready_resp_a: assert property (HREADYOUT && !HRESP) else $error("bus not ready or error");
    led_high_a: assert property (SENSE_A [*6] |-> LED_A)
        else $error("indicator low on high input");
    led_low_a: assert property (!SENSE_A [*6] |-> !LED_A)
        else $error("indicator high on low input");
    highside_float_a: assert property (!DO_A_O && CLIMIT_A != 3'h0 |-> !DO_A_OE)
        else $error("high-side output driven low");
    chan_b_power_a: assert property (PWR_B |-> LED_PORT && !DO_B_OE)
        else $error("power output not shown or clashing");
    trip_off_a: assert property (DIAG_A && $past(DIAG_A) |-> !DO_A_O)
        else $error("tripped output still on");
    filter_time_a: assert property ($rose(DIAG_A) |-> ovl_run >= (FILTER_MS-1)*MS_CYC)
        else $error("diagnostic before filter time");
    err_gate_a: assert property (ALM_ERR |-> $past(DEV_ERR))
        else $error("error alarm without cause");
    notif_gate_a: assert property (ALM_NOTIF |-> $past(DEV_NOTIF))
        else $error("notification without cause");
    valid_net_a: assert property (!NET_LOST [*3] |-> SD_PDOUT_VALID)
        else $error("output data invalid with network up");
endmodule
bind io_port_channel io_port_chk #(.MS_CYC(MS_CYC), .FILTER_MS(FILTER_MS)) u_chk (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .NET_LOST(NET_LOST), .SENSE_A(SENSE_A), .OVL_A(OVL_A), .DO_A_O(DO_A_O),
    .DO_A_OE(DO_A_OE), .CLIMIT_A(CLIMIT_A), .DO_B_OE(DO_B_OE), .PWR_B(PWR_B),
    .LED_A(LED_A), .LED_PORT(LED_PORT), .DIAG_A(DIAG_A), .DEV_ERR(DEV_ERR),
    .DEV_NOTIF(DEV_NOTIF), .ALM_ERR(ALM_ERR), .ALM_NOTIF(ALM_NOTIF),
    .SD_PDOUT_VALID(SD_PDOUT_VALID)
);
`default_nettype wire

// *** tb/io_port_partner.sv ***
// Sensors, actuator load and attached smart device on one port
`default_nettype none
module io_port_partner (
    input wire logic sense_a, // Wanted level, sensor A
    input wire logic sense_b, // Wanted level, sensor B
    input wire logic short_a, // Actuator A shorted
    input wire logic [2:0] alarm_req, // Error, warning, notification
    input wire logic [31:0] pdin, // Device input data
    input wire logic DO_A_O, // Output A level
    input wire logic DO_A_OE, // Output A enable
    output logic SENSE_A, // Sensor A pin
    output logic SENSE_B, // Sensor B pin
    output logic OVL_A, // Driver overload
    output logic DEV_ERR, // Error pulse
    output logic DEV_WARN, // Warning pulse
    output logic DEV_NOTIF, // Notification pulse
    output logic [31:0] SD_PDIN // Device input data
);
    timeunit 1ns / 1ps;
    // A short only draws current while the output sources it
    assign OVL_A = short_a && DO_A_O && DO_A_OE;
    assign SENSE_A = sense_a;
    assign SENSE_B = sense_b;
    assign {DEV_ERR, DEV_WARN, DEV_NOTIF} = alarm_req;
    assign SD_PDIN = pdin;
endmodule
`default_nettype wire

// *** tb/io_port_channel_logic_bench.sv ***
// Self-checking bench for the port channel block
`default_nettype none
`include "io_port_regs.svh"
module io_port_channel_logic_bench import io_port_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    localparam int RST = 4;
    localparam int FLT = 5;
    logic CLK_SYS = 0, RSTN = 0, HSEL = 0, HWRITE = 0, NET_LOST = 0, b;
    logic sense_a = 0, sense_b = 0, short_a = 0;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2, alarm_req = 3'h0, CLIMIT_A;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, pdin = 32'h0, HRDATA, SD_PDOUT, SD_PDIN;
    logic [31:0] rd, d, s, x;
    logic [15:0] co, ci;
    logic HREADYOUT, HRESP, DO_A_O, DO_A_OE, DO_B_O, DO_B_OE, PWR_B, LED_A, LED_PORT;
    logic DIAG_A, ALM_ERR, ALM_WARN, ALM_NOTIF, SD_PDOUT_VALID, SENSE_A, SENSE_B, OVL_A;
    logic DEV_ERR, DEV_WARN, DEV_NOTIF;
    logic [7:0] ofs [8] = '{`OFS_CFG, `OFS_MON, `OFS_CTRL, `OFS_SWAP, `OFS_SDFS, `OFS_SUBST,
        `OFS_PDOUT, 8'h24};
    logic [31:0] rstv [8] = '{`CFG_RST, `MON_RST, `CTRL_RST, `SWAP_RST, `SDFS_RST,
        `SUBST_RST, `PDOUT_RST, 32'h0};
    logic [15:0] corner [4] = '{16'h0004, 16'h0002, 16'h0006, 16'h2101};
    int err_total = 0, n_tests = 0, cyc = 0, mon, n;
    cfg_t cfg;
    always #2.5 CLK_SYS = ~CLK_SYS;
    io_port_channel #(.MS_CYC(MS), .RESTART_MS(RST), .FILTER_MS(FLT)) u_io_port_channel (
        .CLK_SYS(CLK_SYS), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .NET_LOST(NET_LOST),
        .SENSE_A(SENSE_A), .SENSE_B(SENSE_B), .OVL_A(OVL_A), .DO_A_O(DO_A_O),
        .DO_A_OE(DO_A_OE), .CLIMIT_A(CLIMIT_A), .DO_B_O(DO_B_O), .DO_B_OE(DO_B_OE),
        .PWR_B(PWR_B), .LED_A(LED_A), .LED_PORT(LED_PORT), .DIAG_A(DIAG_A),
        .DEV_ERR(DEV_ERR), .DEV_WARN(DEV_WARN), .DEV_NOTIF(DEV_NOTIF), .ALM_ERR(ALM_ERR),
        .ALM_WARN(ALM_WARN), .ALM_NOTIF(ALM_NOTIF), .SD_PDIN(SD_PDIN), .SD_PDOUT(SD_PDOUT),
        .SD_PDOUT_VALID(SD_PDOUT_VALID)
    );
    io_port_partner u_io_port_partner (
        .sense_a(sense_a), .sense_b(sense_b), .short_a(short_a), .alarm_req(alarm_req),
        .pdin(pdin), .DO_A_O(DO_A_O), .DO_A_OE(DO_A_OE), .SENSE_A(SENSE_A),
        .SENSE_B(SENSE_B), .OVL_A(OVL_A), .DEV_ERR(DEV_ERR), .DEV_WARN(DEV_WARN),
        .DEV_NOTIF(DEV_NOTIF), .SD_PDIN(SD_PDIN)
    );
    task automatic final_report();
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Called just after a clock edge; waits on the slave's ready, no fixed latency assumed
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= wr;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        ahb(1'b1, a, wd);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge CLK_SYS);
    endtask
    task automatic wait_diag(input logic lvl);
        n = 0;
        while (DIAG_A !== lvl && n < 2000) begin
            @(posedge CLK_SYS);
            n++;
        end
    endtask
    // Byte 1 sits in the top lane; a partial unit at the tail stays in place
    function automatic logic [31:0] swapped(input logic [31:0] v, input logic [15:0] c);
        logic [7:0] bi [4];
        logic [7:0] bo [4];
        int u, k0;
        u = c[2] ? 4 : 2;
        k0 = c[1:0] == 2'h2 ? 4 : c[11:8];
        for (int i = 0; i < 4; i++) bi[i] = v[31 - 8 * i -: 8];
        bo = bi;
        for (int k = 0; k < k0; k++)
            if (c[1:0] != 2'h0 && c[15:12] + (k + 1) * u <= 4)
                for (int j = 0; j < u; j++) bo[c[15:12]+k*u+j] = bi[c[15:12]+k*u+u-1-j];
        return {bo[0], bo[1], bo[2], bo[3]};
    endfunction
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        void'($urandom(58));
        repeat (20) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        tick(2);
        chk({CLIMIT_A, DO_A_OE}, {3'h4, 1'b0});
        wr(8'h24, 32'hffffffff);
        foreach (ofs[i]) begin
            ahb(1'b0, ofs[i], 32'h0);
            chk(rd, rstv[i]);
        end
        cfg = cfg_t'(`CFG_RST);
        for (int i = 0; i < 8; i++) begin
            cfg.polarity_nc = i[0];
            sense_a <= i[1];
            wr(`OFS_CFG, cfg);
            tick(8);
            ahb(1'b0, `OFS_STAT, 32'h0);
            chk(rd[0], sense_a ^ i[0]);
            chk({rd[2], LED_A}, {2{sense_a}});
        end
        for (int i = 0; i < 6; i++) begin
            cfg.push_pull = i == 5;
            cfg.climit = climit_t'(i > 4 ? 0 : i);
            wr(`OFS_CFG, cfg);
            wr(`OFS_CTRL, 32'h1);
            tick(3);
            chk({DO_A_O, DO_A_OE, CLIMIT_A}, {2'b11, 3'(i > 4 ? 0 : i)});
            wr(`OFS_CTRL, 32'h0);
            tick(3);
            chk({DO_A_O, DO_A_OE}, {1'b0, cfg.push_pull});
        end
        sense_b <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            cfg.chb_mode = chb_t'(i);
            wr(`OFS_CFG, cfg);
            wr(`OFS_CTRL, 32'h2);
            tick(8);
            chk({DO_B_O, DO_B_OE, PWR_B, LED_PORT}, {{2{i == 2}}, {2{i == 3}}});
            ahb(1'b0, `OFS_STAT, 32'h0);
            chk(rd[1], i == 1);
        end
        cfg.push_pull = 1'b0;
        for (int m = 0; m < 2; m++) begin
            mon = $urandom_range(6, 3);
            cfg.restart_manual = m[0];
            wr(`OFS_CFG, cfg);
            wr(`OFS_MON, mon);
            short_a <= 1'b1;
            wr(`OFS_CTRL, 32'h1);
            wait_diag(1'b1);
            chk(n >= (mon + FLT - 2) * MS && n <= (mon + FLT + 1) * MS, 1);
            if (m == 0) begin
                wait_diag(1'b0);
                chk(n >= (RST - 1) * MS && n <= (RST + 1) * MS, 1);
                tick(1);
                chk(DO_A_O, 1);
            end else begin
                tick(3 * RST * MS);
                chk({DIAG_A, DO_A_O}, 2'b10);
                cfg.diag_en = 1'b0;
                wr(`OFS_CFG, cfg);
                tick(2);
                chk(DIAG_A, 0);
                cfg.diag_en = 1'b1;
                short_a <= 1'b0;
                wr(`OFS_CTRL, 32'h1);
                tick(2);
                chk(DO_A_O, 0);
                wr(`OFS_CTRL, 32'h0);
                wr(`OFS_CTRL, 32'h1);
                tick(3);
                chk(DO_A_O, 1);
            end
            short_a <= 1'b0;
            wr(`OFS_CTRL, 32'h0);
        end
        cfg.restart_manual = 1'b0;
        for (int i = 0; i < 6; i++) begin
            cfg.fs_do = fs_do_t'(i % 3);
            wr(`OFS_CFG, cfg);
            b = 1'($urandom_range(1));
            wr(`OFS_CTRL, {31'h0, b});
            tick(1);
            NET_LOST <= 1'b1;
            tick(3);
            chk(DO_A_O, i % 3 == 0 ? 1'b0 : (i % 3 == 1 ? 1'b1 : b));
            NET_LOST <= 1'b0;
        end
        for (int i = 0; i < 12; i++) begin
            co = i < 4 ? corner[i] : {4'($urandom_range(3)), 4'($urandom_range(2)), 5'h0,
                1'($urandom_range(1)), 2'($urandom_range(2))};
            ci = {4'($urandom_range(3)), 4'($urandom_range(2)), 6'h0, 2'($urandom_range(2))};
            d = $urandom();
            x = $urandom();
            pdin <= x;
            wr(`OFS_SWAP, {co, ci});
            wr(`OFS_PDOUT, d);
            tick(2);
            chk(SD_PDOUT, swapped(d, co));
            ahb(1'b0, `OFS_PDIN, 32'h0);
            chk(rd, swapped(x, ci));
        end
        wr(`OFS_SWAP, 32'h0);
        wr(`OFS_PDOUT, d);
        NET_LOST <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            s = $urandom();
            wr(`OFS_SUBST, s);
            wr(`OFS_SDFS, {28'h0, 1'($urandom_range(1)), 3'(i)});
            tick(2);
            x = i == 0 ? 32'h0 : (i == 1 ? 32'hffffffff : (i == 3 ? s : d));
            chk({SD_PDOUT_VALID, SD_PDOUT}, {i != 4, x});
        end
        NET_LOST <= 1'b0;
        tick(2);
        chk({SD_PDOUT_VALID, SD_PDOUT}, {1'b1, d});
        for (int i = 0; i < 4; i++) begin
            cfg.diag_en = i[0];
            cfg.notif_en = i[1];
            wr(`OFS_CFG, cfg);
            alarm_req <= 3'h7;
            @(posedge CLK_SYS);
            alarm_req <= 3'h0;
            @(posedge CLK_SYS);
            chk({ALM_ERR, ALM_WARN, ALM_NOTIF}, {i[0], i[0], i[1]});
        end
        final_report();
    end
endmodule
`default_nettype wire
